// ### rtl/tmb_defs.vh
// Register offsets, field positions, mode codes and reset values of the timer block
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH
`define TMB_ADDR_W 4
`define TMB_OFF_FLAGS 4'h6
`define TMB_OFF_STATUS 4'h7
`define TMB_OFF_DEBUG 4'h8
`define TMB_OFF_STAGE 4'h9
`define TMB_OFF_COUNT_LO 4'hA
`define TMB_OFF_COUNT_HI 4'hB
`define TMB_OFF_CMP_LO 4'hC
`define TMB_OFF_CMP_HI 4'hD
`define TMB_BIT_FLAG 0
`define TMB_BIT_RUN 0
`define TMB_BIT_KEEP_RUN 0
`define TMB_RST8 8'h00
`define TMB_RST16 16'h0000
`define TMB_MODE_PERIODIC 3'h0
`define TMB_MODE_TIMEOUT 3'h1
`define TMB_MODE_ON_EVENT 3'h2
`define TMB_MODE_FRQ 3'h3
`define TMB_MODE_PW 3'h4
`define TMB_MODE_FRQPW 3'h5
`define TMB_MODE_SINGLE 3'h6
`define TMB_MODE_PWM8 3'h7
`endif

// ### rtl/tmb_edge_detect.v
// Two-flop synchroniser for the event input plus rise/fall pulse detection
`timescale 1ns/1ps
module tmb_edge_detect (
  core_clk,
  rst_b,
  evIn,
  evRise,
  evFall
);
  input wire core_clk;
  input wire rst_b;
  input wire evIn;
  output wire evRise;
  output wire evFall;
  reg sync1_r;
  reg sync2_r;
  reg last_r;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      sync1_r <= evIn;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
    end
  end
  assign evRise = sync2_r & ~last_r;
  assign evFall = ~sync2_r & last_r;
endmodule // tmb_edge_detect

// ### rtl/tmb_regfile.v
// Byte-wide register read multiplexer with reserved bits reading as zero
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tmb_regfile (
  addr,
  irqFlag,
  running,
  debug_keep_running,
  pwmMode,
  stage,
  cnt,
  cmpVal,
  rdData
);
  input wire [`TMB_ADDR_W-1:0] addr;
  input wire irqFlag;
  input wire running;
  input wire debug_keep_running;
  input wire pwmMode;
  input wire [7:0] stage;
  input wire [15:0] cnt;
  input wire [15:0] cmpVal;
  output reg [7:0] rdData;
  always @* begin
    rdData = `TMB_RST8;
    case (addr)
      `TMB_OFF_FLAGS: rdData[`TMB_BIT_FLAG] = irqFlag;
      `TMB_OFF_STATUS: rdData[`TMB_BIT_RUN] = running;
      `TMB_OFF_DEBUG: rdData[`TMB_BIT_KEEP_RUN] = debug_keep_running;
      `TMB_OFF_STAGE: rdData = stage;
      `TMB_OFF_COUNT_LO: rdData = cnt[7:0];
      `TMB_OFF_COUNT_HI: rdData = stage;
      `TMB_OFF_CMP_LO: rdData = cmpVal[7:0];
      // Both compare bytes stand alone in PWM mode, so no staging there
      `TMB_OFF_CMP_HI: rdData = pwmMode ? cmpVal[15:8] : stage;
      default: rdData = `TMB_RST8;
    endcase
  end
endmodule // tmb_regfile

// ### rtl/tmb_timer.v
// Capture/compare timer core: flag, status, debug halt, staging, counter and compare
`timescale 1ns/1ps
`include "tmb_defs.vh"
module tmb_timer (
  core_clk,
  rst_b,
  enable,
  counterModeSelect,
  eventEdge,
  eventInputEnable,
  evIn,
  debugHalt,
  busAddr,
  busWrEn,
  busRdEn,
  busWrData,
  busRdData,
  captureInterruptFlag,
  pwmOut
);
  input wire core_clk;
  input wire rst_b;
  input wire enable;
  input wire [2:0] counterModeSelect;
  input wire eventEdge;
  input wire eventInputEnable;
  input wire evIn;
  input wire debugHalt;
  input wire [`TMB_ADDR_W-1:0] busAddr;
  input wire busWrEn;
  input wire busRdEn;
  input wire [7:0] busWrData;
  output reg [7:0] busRdData;
  output reg captureInterruptFlag;
  output reg pwmOut;

  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg [15:0] cmp_r;
  reg [15:0] cmp_nxt;
  reg [7:0] stage_r;
  reg [7:0] stage_nxt;
  reg debug_keep_running_r;
  reg run_r;
  reg run_nxt;
  reg flag_nxt;
  reg pwm_nxt;
  reg [1:0] fpState_r;
  reg [1:0] fpState_nxt;
  reg evGateSync1_r;
  reg enSync_r;
  reg haltSync1_r;
  reg haltSync2_r;
  wire evRise;
  wire evFall;
  wire [7:0] rdMux;
  wire halted;
  wire actEdge;
  wire oppEdge;
  wire isCapMode;
  wire pwmMode;
  wire wrStrobe;
  wire rdStrobe;
  reg setFlag;

  localparam FP_IDLE = 2'b00;
  localparam FP_COUNT = 2'b01;
  localparam FP_MEASURED = 2'b10;

  tmb_edge_detect u_edge (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .evIn(evIn),
    .evRise(evRise),
    .evFall(evFall)
  );

  tmb_regfile u_regs (
    .addr(busAddr),
    .irqFlag(captureInterruptFlag),
    .running(run_r),
    .debug_keep_running(debug_keep_running_r),
    .pwmMode(pwmMode),
    .stage(stage_r),
    .cnt(cnt_r),
    .cmpVal(cmp_r),
    .rdData(rdMux)
  );

  // Halt request comes from the debug domain, so synchronise it first
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      haltSync1_r <= 1'b0;
      haltSync2_r <= 1'b0;
      evGateSync1_r <= 1'b0;
      enSync_r <= 1'b0;
    end else begin
      haltSync1_r <= debugHalt;
      haltSync2_r <= haltSync1_r;
      evGateSync1_r <= enable;
      enSync_r <= evGateSync1_r;
    end
  end

  assign halted = haltSync2_r & ~debug_keep_running_r;
  assign wrStrobe = busWrEn;
  assign rdStrobe = busRdEn & ~busWrEn;
  // Edge select zero makes the rising edge the active one
  assign actEdge = eventInputEnable & ~halted & (eventEdge ? evFall : evRise);
  assign oppEdge = eventInputEnable & ~halted & (eventEdge ? evRise : evFall);
  assign pwmMode = (counterModeSelect == `TMB_MODE_PWM8);
  assign isCapMode = (counterModeSelect == `TMB_MODE_ON_EVENT) ||
    (counterModeSelect == `TMB_MODE_FRQ) || (counterModeSelect == `TMB_MODE_PW) ||
    (counterModeSelect == `TMB_MODE_FRQPW);

  always @* begin
    cnt_nxt = cnt_r;
    cmp_nxt = cmp_r;
    stage_nxt = stage_r;
    run_nxt = run_r;
    pwm_nxt = pwmOut;
    fpState_nxt = fpState_r;
    setFlag = 1'b0;
    if (!enSync_r) begin
      run_nxt = 1'b0;
      fpState_nxt = FP_IDLE;
    end else if (!halted) begin
      case (counterModeSelect)
        `TMB_MODE_PERIODIC, `TMB_MODE_TIMEOUT, `TMB_MODE_SINGLE: begin
          if (counterModeSelect == `TMB_MODE_PERIODIC) begin
            run_nxt = 1'b1;
          end else if (counterModeSelect == `TMB_MODE_TIMEOUT) begin
            if (actEdge) begin
              run_nxt = 1'b1;
            end else if (oppEdge) begin
              run_nxt = 1'b0;
            end
          end else if (actEdge || (eventEdge && oppEdge)) begin
            run_nxt = 1'b1;
            cnt_nxt = `TMB_RST16;
          end
          if (run_r) begin
            if (cnt_r == cmp_r) begin
              setFlag = 1'b1;
              cnt_nxt = `TMB_RST16;
              if (counterModeSelect == `TMB_MODE_SINGLE) begin
                run_nxt = 1'b0;
              end
            end else begin
              cnt_nxt = cnt_r + 16'h0001;
            end
          end
        end
        `TMB_MODE_ON_EVENT: begin
          run_nxt = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
          if (actEdge) begin
            cmp_nxt = cnt_r;
            setFlag = 1'b1;
          end
        end
        `TMB_MODE_FRQ: begin
          run_nxt = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
          if (actEdge) begin
            cmp_nxt = cnt_r;
            cnt_nxt = `TMB_RST16;
            setFlag = 1'b1;
          end
        end
        `TMB_MODE_PW: begin
          run_nxt = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
          // Selected edge starts the pulse; the opposite edge ends and captures it
          if (actEdge) begin
            cnt_nxt = `TMB_RST16;
          end else if (oppEdge) begin
            cmp_nxt = cnt_r;
            setFlag = 1'b1;
          end
        end
        `TMB_MODE_FRQPW: begin
          if (run_r) begin
            cnt_nxt = cnt_r + 16'h0001;
          end
          case (fpState_r)
            FP_IDLE: if (actEdge) begin
              cnt_nxt = `TMB_RST16;
              run_nxt = 1'b1;
              fpState_nxt = FP_COUNT;
            end
            FP_COUNT: if (oppEdge) begin
              cmp_nxt = cnt_r;
              fpState_nxt = FP_MEASURED;
            end
            FP_MEASURED: if (actEdge) begin
              run_nxt = 1'b0;
              cnt_nxt = cnt_r;
              setFlag = 1'b1;
              fpState_nxt = FP_IDLE;
            end
            default: fpState_nxt = FP_IDLE;
          endcase
        end
        `TMB_MODE_PWM8: begin
          run_nxt = 1'b1;
          // Low byte is period, high byte is duty; both bytes stand alone
          if (cnt_r[7:0] == cmp_r[7:0]) begin
            setFlag = 1'b1;
            cnt_nxt = `TMB_RST16;
            pwm_nxt = 1'b1;
          end else begin
            cnt_nxt = {8'h00, cnt_r[7:0] + 8'h01};
            if (cnt_r[7:0] == cmp_r[15:8]) begin
              pwm_nxt = 1'b0;
            end
          end
        end
        default: run_nxt = 1'b0;
      endcase
    end
    // Bus side: writes override internal updates above
    if (wrStrobe) begin
      case (busAddr)
        `TMB_OFF_STAGE, `TMB_OFF_COUNT_HI, `TMB_OFF_CMP_HI: stage_nxt = busWrData;
        `TMB_OFF_COUNT_LO: cnt_nxt = {stage_r, busWrData};
        `TMB_OFF_CMP_LO: begin
          if (pwmMode) begin
            cmp_nxt[7:0] = busWrData;
          end else begin
            cmp_nxt = {stage_r, busWrData};
          end
        end
        default: stage_nxt = stage_r;
      endcase
      // In PWM mode the high compare byte is written directly
      if (busAddr == `TMB_OFF_CMP_HI && pwmMode) begin
        cmp_nxt[15:8] = busWrData;
      end
    end else if (rdStrobe) begin
      if (busAddr == `TMB_OFF_COUNT_LO) begin
        stage_nxt = cnt_r[15:8];
      end else if (busAddr == `TMB_OFF_CMP_LO) begin
        stage_nxt = cmp_r[15:8];
      end
    end
    // Set beats clear when both land in one cycle
    flag_nxt = captureInterruptFlag;
    if (wrStrobe && busAddr == `TMB_OFF_FLAGS && busWrData[`TMB_BIT_FLAG]) begin
      flag_nxt = 1'b0;
    end
    if (rdStrobe && isCapMode && busAddr == `TMB_OFF_CMP_LO) begin
      flag_nxt = 1'b0;
    end
    if (setFlag) begin
      flag_nxt = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= `TMB_RST16;
      cmp_r <= `TMB_RST16;
      stage_r <= `TMB_RST8;
      debug_keep_running_r <= 1'b0;
      run_r <= 1'b0;
      fpState_r <= FP_IDLE;
      captureInterruptFlag <= 1'b0;
      pwmOut <= 1'b0;
      busRdData <= `TMB_RST8;
    end else begin
      cnt_r <= cnt_nxt;
      cmp_r <= cmp_nxt;
      stage_r <= stage_nxt;
      run_r <= run_nxt;
      fpState_r <= fpState_nxt;
      captureInterruptFlag <= flag_nxt;
      pwmOut <= pwm_nxt;
      busRdData <= rdMux;
      if (wrStrobe && busAddr == `TMB_OFF_DEBUG) begin
        debug_keep_running_r <= busWrData[`TMB_BIT_KEEP_RUN];
      end
    end
  end
endmodule // tmb_timer

// ### verification/tmb_asserts.sv
// Checker of flag and register read behaviour of the timer core
`timescale 1ns/1ps
module tmb_asserts (
  input wire core_clk,
  input wire rst_b,
  input wire [2:0] counterModeSelect,
  input wire evIn,
  input wire [3:0] busAddr,
  input wire busWrEn,
  input wire busRdEn,
  input wire [7:0] busWrData,
  input wire [7:0] busRdData,
  input wire captureInterruptFlag
);
  logic [4:0] evHist;
  logic quiet;
  always @(posedge core_clk) evHist <= {evHist[3:0], evIn};
  // No event edge may still sit in the synchroniser
  assign quiet = (evHist == {5{evIn}});
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_flag_wone: assert property (
    busWrEn && busAddr == 4'h6 && busWrData[0] && quiet && counterModeSelect == 3'h2
    |=> !captureInterruptFlag) else $error("flag not cleared by write");
  a_flag_rdclr: assert property (
    busRdEn && !busWrEn && busAddr == 4'hC && quiet && counterModeSelect inside {[3'h2:3'h5]}
    |=> !captureInterruptFlag) else $error("flag not cleared by read");
  a_flag_holds: assert property (
    captureInterruptFlag && !busWrEn && !busRdEn |=> captureInterruptFlag)
    else $error("flag dropped");
  a_unmapped_zero: assert property (
    busAddr < 4'h6 || busAddr > 4'hD |=> busRdData == 8'h00) else $error("unmapped read");
  a_status_rsv: assert property (
    busAddr == 4'h7 |=> busRdData[7:1] == 7'h00) else $error("status bits");
  a_dbg_rsv: assert property (
    busAddr == 4'h8 |=> busRdData[7:1] == 7'h00) else $error("debug bits");
  a_flag_read: assert property (
    busAddr == 4'h6 |=> busRdData == {7'h00, $past(captureInterruptFlag)})
    else $error("flag read");
  a_stage_back: assert property (
    busWrEn && busAddr == 4'h9 ##1 !busWrEn && busAddr == 4'h9
    |=> busRdData == $past(busWrData, 2)) else $error("staging read");
endmodule // tmb_asserts
bind tmb_timer tmb_asserts chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .counterModeSelect(counterModeSelect), .evIn(evIn), .busAddr(busAddr),
  .busWrEn(busWrEn), .busRdEn(busRdEn), .busWrData(busWrData),
  .busRdData(busRdData), .captureInterruptFlag(captureInterruptFlag));

// ### verification/tmb_evsrc.sv
// Event source standing in for the event routing network
`timescale 1ns/1ps
module tmb_evsrc #(
  parameter int WIDTH = 30
) (
  input wire core_clk,
  input wire evReq,
  output wire evOut
);
  int cnt = 0;
  // One level pulse per request; its fall is a second edge in some modes
  always @(posedge core_clk) begin
    if (evReq)
      cnt <= WIDTH;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign evOut = (cnt != 0);
endmodule // tmb_evsrc

// ### verification/tmb_timer_test.sv
// Self-checking testbench of the timer core
`timescale 1ns/1ps
module tmb_timer_test;
  logic core_clk = 0, rst_b = 0, enable = 0, eventEdge = 0, eventInputEnable = 0;
  logic debugHalt = 0, busWrEn = 0, busRdEn = 0, evReq = 0;
  logic evIn, captureInterruptFlag, pwmOut;
  logic [2:0] counterModeSelect = 3'h0;
  logic [3:0] busAddr = 4'h0;
  logic [7:0] busWrData = 8'h00, busRdData, v, c;
  int failures = 0, samples_checked = 0, hi;
  tmb_timer dut_u (.core_clk(core_clk), .rst_b(rst_b), .enable(enable),
    .counterModeSelect(counterModeSelect), .eventEdge(eventEdge),
    .eventInputEnable(eventInputEnable), .evIn(evIn), .debugHalt(debugHalt),
    .busAddr(busAddr), .busWrEn(busWrEn), .busRdEn(busRdEn), .busWrData(busWrData),
    .busRdData(busRdData), .captureInterruptFlag(captureInterruptFlag), .pwmOut(pwmOut));
  tmb_evsrc ev_u (.core_clk(core_clk), .evReq(evReq), .evOut(evIn));
  initial forever #5 core_clk = ~core_clk;
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(negedge core_clk);
    busAddr = a;
    busWrData = d;
    busWrEn = 1;
    @(negedge core_clk);
    busWrEn = 0;
  endtask
  task rd(input [3:0] a);
    @(negedge core_clk);
    busAddr = a;
    busRdEn = 1;
    @(negedge core_clk);
    busRdEn = 0;
    v = busRdData;
  endtask
  task ev;
    @(negedge core_clk);
    evReq = 1;
    @(negedge core_clk);
    evReq = 0;
    repeat (45) @(negedge core_clk);
  endtask
  task cnt0;
    wr(4'hB, 8'h00);
    wr(4'hA, 8'h00);
  endtask
  task t_reset;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0]);
      chk(v, 0);
    end
    wr(4'h7, 8'hFF);
    wr(4'hE, 8'hFF);
    rd(4'h7);
    chk(v, 0);
    rd(4'hE);
    chk(v, 0);
  endtask
  task t_wide;
    wr(4'h9, 8'h5A);
    rd(4'h9);
    chk(v, 8'h5A);
    wr(4'hB, 8'h12);
    wr(4'hA, 8'h34);
    rd(4'hA);
    chk(v, 8'h34);
    rd(4'h9);
    chk(v, 8'h12);
    wr(4'hD, 8'hFF);
    wr(4'hC, 8'hFF);
    enable = 1;
    wr(4'hB, 8'h56);
    wr(4'hA, 8'h78);
    rd(4'hA);
    chk(v > 8'h77 && v < 8'h80, 1);
    rd(4'hB);
    chk(v, 8'h56);
  endtask
  task t_top;
    // Time-out needs the event to start and stop the count; single-shot starts on it and stops itself at the compare match
    eventInputEnable = 1;
    wr(4'hD, 8'h00);
    wr(4'hC, 8'h08);
    for (int i = 0; i < 3; i++) begin
      counterModeSelect = (i == 2) ? 3'h6 : i[2:0];
      cnt0;
      ev;
      chk(captureInterruptFlag, 1);
      rd(4'hA);
      chk(v <= 8'h08, 1);
      rd(4'h7);
      chk(v, i == 0);
      wr(4'h6, 8'h01);
      if (i != 0) chk(captureInterruptFlag, 0);
    end
  endtask
  task t_capture_interrupt_flag;
    eventInputEnable = 1;
    for (int m = 2; m < 6; m++) begin
      counterModeSelect = m[2:0];
      cnt0;
      ev;
      if (m == 5) ev;
      chk(captureInterruptFlag, 1);
      if (m == 2) wr(4'h6, 8'h01);
      rd(4'hC);
      if (m == 2) chk(v > 0 && v < 8'h20, 1);
      if (m == 4) chk(v > 8'h1B && v < 8'h1F, 1);
      chk(captureInterruptFlag, 0);
    end
  endtask
  task t_debug;
    counterModeSelect = 3'h2;
    debugHalt = 1;
    repeat (4) @(negedge core_clk);
    ev;
    chk(captureInterruptFlag, 0);
    rd(4'hA);
    c = v;
    rd(4'hA);
    chk(v, c);
    wr(4'h8, 8'h01);
    rd(4'h8);
    chk(v, 1);
    c = v;
    rd(4'hA);
    c = v;
    rd(4'hA);
    chk(v != c, 1);
    debugHalt = 0;
    wr(4'h8, 8'h00);
  endtask
  task t_pwm;
    counterModeSelect = 3'h7;
    wr(4'hC, 8'h04);
    wr(4'hD, 8'h02);
    // Spoil the staging byte so a high-byte read through it shows
    wr(4'h9, 8'hAA);
    rd(4'hD);
    chk(v, 8'h02);
    rd(4'hC);
    chk(v, 8'h04);
    cnt0;
    wr(4'h6, 8'h01);
    repeat (12) @(negedge core_clk);
    chk(captureInterruptFlag, 1);
    hi = 0;
    // Five whole periods, so the count does not depend on phase
    repeat (25) begin
      @(negedge core_clk);
      hi += pwmOut;
    end
    // High for duty plus one of every period plus one cycles
    chk(hi, 15);
  endtask
  task test_done;
    $display("Checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1;
    t_reset;
    t_wide;
    t_top;
    t_capture_interrupt_flag;
    t_debug;
    t_pwm;
    test_done;
  end
  initial begin
    #200000;
    failures++;
    test_done;
  end
endmodule // tmb_timer_test
